// >>> sled_flash.sv
// flash timebase: square wave with equal halves
// assumes sys_rst is synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module sled_flash
  import sled_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = FLASH_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  sled_tb_if.src tb
);
  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
  } sled_fl_t;
  sled_fl_t s_reg;
  sled_fl_t s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.cnt == 32'(HALF_CYCLES - 1)) begin
      s_next.cnt = 32'h0;
      s_next.phase = ~s_reg.phase;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tb.phase = s_reg.phase;

  property p_even_half;
    @(posedge clock) disable iff (sys_rst)
      (s_reg.phase != $past(s_reg.phase)) |-> s_reg.cnt == 32'h0;
  endproperty
  a_even_half: assert property (p_even_half)
    else $error("flash phase changed off the half-period boundary");

  property p_cnt_bound;
    @(posedge clock) disable iff (sys_rst)
      s_reg.cnt < 32'(HALF_CYCLES);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("flash counter passed its half period");
endmodule
`default_nettype wire

// >>> sled_lamps.sv
// lamp panel model: integrates lamp levels over a watch window
// assumes high-active lamp levels on the bench clock
`timescale 1ns/1ps
`default_nettype none
module sled_lamps (
  input wire logic clock,
  input wire logic clr,
  input wire logic [8:0] lamp,
  output logic [8:0] and_v,
  output logic [8:0] or_v
);
  // lit every cycle reads steady, lit in some cycles reads flashing
  always_ff @(posedge clock) begin
    if (clr) begin
      and_v <= 9'h1FF;
      or_v <= 9'h000;
    end else begin
      and_v <= and_v & lamp;
      or_v <= or_v | lamp;
    end
  end
endmodule
`default_nettype wire

// >>> sled_pkg.sv
// constants and types for the status lamp driver
// assumes one 200 MHz clock and lamps driven high-active by the pins
//
// Contract
// - stopped mode shows the mode lamp steady yellow.
// - running mode shows the mode lamp steady green.
// - startup mode flashes the mode lamp alternating green and yellow.
// - startup, self-test or firmware update alternate mode lamp, maintenance dark.
// - internal, card or configuration mismatch error flashes the error lamp.
// - defective hardware: error steady red, mode steady yellow, maintenance dark.
// - card insertion flashes maintenance lamp and forces the stopped mode.
// - after card stop, evaluation starts only on run, memory reset or power up.
// - card removal signalled: mode steady yellow, maintenance lamp flashing.
// - maintenance request lights maintenance steady; mode lamp follows mode.
// - lamp test or bad firmware flashes all three lamps, mode alternating.
// - link lamp green while the network connection is established.
// - traffic lamp yellow while network transmission is active.
// - each digital channel lamp green mirrors its channel state.
// - module health lamp green when operational, red when defective.
// - analogue channel green when configured and active, red on error.
// - field power absent flashes health and channel lamps red.
// - unconfigured or updating module flashes health green, channels dark.
// - configured error-free module holds health and channels steady green.
// - channel error flashes red with diagnostics on, stays green otherwise.
package sled_pkg;
  localparam int N_DIG = 16;
  localparam int N_ANA = 4;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam int CTRL_MAINTENANCE_INDICATOR_BIT = 0;
  localparam int CTRL_LTEST_BIT = 1;
  localparam int CTRL_MODULE_HEALTH_INDICATOR_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  localparam int CMD_RUN_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_MEMORY_RESET_COMMAND_BIT = 2;
  localparam int STAT_HOLD_BIT = 3;
  localparam int STAT_MODE_Y_BIT = 4;
  localparam int STAT_MODE_G_BIT = 5;
  localparam int STAT_ERR_BIT = 6;
  localparam int STAT_MAINTENANCE_INDICATOR_BIT = 7;
  localparam int STAT_HEALTH_G_BIT = 8;
  localparam int STAT_HEALTH_R_BIT = 9;
  localparam logic [7:0] STARTUP_CYCLES = 8'h10;
  localparam int CLK_KHZ = 200000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_KHZ;
  typedef enum logic [2:0] {
    MODE_STOP = 3'b001,
    MODE_START = 3'b010,
    MODE_RUN = 3'b100
  } sled_mode_t;
endpackage

// >>> sled_tb_if.sv
// shared flash phase between the timebase and the lamp logic
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sled_tb_if;
  logic phase;
  modport src (output phase);
  modport dst (input phase);
endinterface
`default_nettype wire

// >>> sled_top.sv
// status lamp driver for a controller cpu and one signal module
// assumes apb master on clock, condition inputs synchronous to clock
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sled_top
  import sled_pkg::*;
#(
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_internal_error,
  input wire logic card_error,
  input wire logic config_mismatch,
  input wire logic hw_defect,
  input wire logic fw_defect,
  input wire logic self_test,
  input wire logic fw_update,
  input wire logic card_insert,
  input wire logic card_remove,
  input wire logic net_link,
  input wire logic net_activity,
  input wire logic [N_DIG-1:0] dig_state,
  input wire logic field_power_ok,
  input wire logic mod_configured,
  input wire logic mod_updating,
  input wire logic mod_defect,
  input wire logic [N_ANA-1:0] ana_active,
  input wire logic [N_ANA-1:0] ana_error,
  output logic card_eval,
  output logic mode_yellow,
  output logic mode_green,
  output logic error_red,
  output logic maintenance_indicator,
  output logic link_green,
  output logic traffic_yellow,
  output logic [N_DIG-1:0] chan_green,
  output logic [N_DIG-1:0] chan_red,
  output logic health_green,
  output logic health_red,
  output logic [N_ANA-1:0] ana_green,
  output logic [N_ANA-1:0] ana_red
);
  typedef struct packed {
    sled_mode_t mode;
    logic [7:0] start_cnt;
    logic card_hold;
    logic maintenance_indicator_flash;
    logic boot;
    logic eval;
    logic [2:0] ctrl;
    logic mode_y;
    logic mode_g;
    logic err_r;
    logic maintenance_indicator_y;
    logic link_g;
    logic traf_y;
    logic [N_DIG-1:0] chan_g;
    logic [N_DIG-1:0] chan_r;
    logic hl_g;
    logic hl_r;
    logic [N_ANA-1:0] ana_g;
    logic [N_ANA-1:0] ana_r;
  } sled_state_t;

  sled_state_t s_reg;
  sled_state_t s_next;
  sled_tb_if tb ();

  sled_flash #(
    .HALF_CYCLES(FLASH_HALF)
  ) u_flash (
    .clock(clock),
    .sys_rst(sys_rst),
    .tb(tb.src)
  );

  logic ph;
  logic wr_ctrl;
  logic wr_cmd;
  logic run_req;
  logic stop_req;
  logic memory_reset_command_req;
  logic all_flash;
  logic alt_mode;
  logic err_any;
  logic mod_ok;

  assign ph = tb.phase;
  // zero wait state slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_ctrl = psel && penable && pwrite && (paddr == ADDR_CTRL);
  assign wr_cmd = psel && penable && pwrite && (paddr == ADDR_CMD);
  assign run_req = wr_cmd && pwdata[CMD_RUN_BIT];
  assign stop_req = wr_cmd && pwdata[CMD_STOP_BIT];
  assign memory_reset_command_req = wr_cmd && pwdata[CMD_MEMORY_RESET_COMMAND_BIT];
  assign all_flash = s_reg.ctrl[CTRL_LTEST_BIT] || fw_defect;
  assign alt_mode = (s_reg.mode == MODE_START) || self_test || fw_update;
  assign err_any = cpu_internal_error || card_error || config_mismatch;
  assign mod_ok = field_power_ok && mod_configured && !mod_updating
      && !mod_defect;

  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h0;
    if (psel && penable) begin
      unique case (paddr)
        ADDR_CTRL: prdata[2:0] = s_reg.ctrl;
        ADDR_CMD: prdata = 32'h0;
        ADDR_STAT: begin
          prdata[2:0] = s_reg.mode;
          prdata[STAT_HOLD_BIT] = s_reg.card_hold;
          prdata[STAT_MODE_Y_BIT] = s_reg.mode_y;
          prdata[STAT_MODE_G_BIT] = s_reg.mode_g;
          prdata[STAT_ERR_BIT] = s_reg.err_r;
          prdata[STAT_MAINTENANCE_INDICATOR_BIT] = s_reg.maintenance_indicator_y;
          prdata[STAT_HEALTH_G_BIT] = s_reg.hl_g;
          prdata[STAT_HEALTH_R_BIT] = s_reg.hl_r;
        end
        default: pslverr = 1'b1;
      endcase
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.boot = 1'b0;
    if (wr_ctrl) begin
      s_next.ctrl = pwdata[2:0];
    end
    // power up counts as an evaluation trigger, like run or memory reset
    s_next.eval = s_reg.boot;
    unique case (s_reg.mode)
      MODE_STOP: begin
        if (run_req) begin
          s_next.mode = MODE_START;
          s_next.start_cnt = 8'h0;
        end
      end
      MODE_START: begin
        if (s_reg.start_cnt == STARTUP_CYCLES - 8'h1) begin
          s_next.mode = MODE_RUN;
        end else begin
          s_next.start_cnt = s_reg.start_cnt + 8'h1;
        end
        if (stop_req) begin
          s_next.mode = MODE_STOP;
        end
      end
      MODE_RUN: begin
        if (stop_req) begin
          s_next.mode = MODE_STOP;
        end
      end
      // a non one-hot code can only come from an upset: fall back to stop
      default: s_next.mode = MODE_STOP;
    endcase
    if (s_reg.card_hold && (run_req || memory_reset_command_req)) begin
      s_next.eval = 1'b1;
      s_next.card_hold = 1'b0;
      s_next.maintenance_indicator_flash = 1'b0;
    end
    // insertion wins over a clear arriving in the same cycle
    if (card_insert) begin
      s_next.mode = MODE_STOP;
      s_next.card_hold = 1'b1;
      s_next.maintenance_indicator_flash = 1'b1;
    end
    if (hw_defect) begin
      s_next.mode = MODE_STOP;
    end

    // cpu lamps, lowest priority first: the last assignment wins
    s_next.mode_y = (s_reg.mode == MODE_STOP);
    s_next.mode_g = (s_reg.mode == MODE_RUN);
    s_next.err_r = err_any && ph;
    s_next.maintenance_indicator_y = s_reg.ctrl[CTRL_MAINTENANCE_INDICATOR_BIT];
    if (s_reg.maintenance_indicator_flash) begin
      s_next.maintenance_indicator_y = ph;
    end
    if (card_remove) begin
      s_next.mode_y = 1'b1;
      s_next.mode_g = 1'b0;
      s_next.maintenance_indicator_y = ph;
    end
    if (alt_mode) begin
      s_next.mode_y = ph;
      s_next.mode_g = ~ph;
      s_next.maintenance_indicator_y = 1'b0;
    end
    if (hw_defect) begin
      s_next.mode_y = 1'b1;
      s_next.mode_g = 1'b0;
      s_next.err_r = 1'b1;
      s_next.maintenance_indicator_y = 1'b0;
    end
    if (all_flash) begin
      s_next.mode_y = ph;
      s_next.mode_g = ~ph;
      s_next.err_r = ph;
      s_next.maintenance_indicator_y = ph;
    end
    s_next.link_g = net_link;
    s_next.traf_y = net_activity;

    // module lamps; the field power fault wins over the channel view
    s_next.hl_g = 1'b1;
    s_next.hl_r = 1'b0;
    s_next.chan_g = dig_state;
    s_next.chan_r = '0;
    for (int i = 0; i < N_ANA; i++) begin
      s_next.ana_g[i] = ana_active[i];
      s_next.ana_r[i] = 1'b0;
      if (ana_error[i]) begin
        if (s_reg.ctrl[CTRL_MODULE_HEALTH_INDICATOR_BIT]) begin
          s_next.ana_g[i] = 1'b0;
          s_next.ana_r[i] = ph;
        end else begin
          s_next.ana_g[i] = 1'b1;
        end
      end
    end
    if (mod_defect) begin
      s_next.hl_g = 1'b0;
      s_next.hl_r = 1'b1;
    end
    if (!mod_configured || mod_updating) begin
      s_next.hl_g = ph;
      s_next.hl_r = 1'b0;
      s_next.chan_g = '0;
      s_next.ana_g = '0;
      s_next.ana_r = '0;
    end
    if (!field_power_ok) begin
      s_next.hl_g = 1'b0;
      s_next.hl_r = ph;
      s_next.chan_g = '0;
      s_next.chan_r = {N_DIG{ph}};
      s_next.ana_g = '0;
      s_next.ana_r = {N_ANA{ph}};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.mode <= MODE_STOP;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.boot <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign card_eval = s_reg.eval;
  assign mode_yellow = s_reg.mode_y;
  assign mode_green = s_reg.mode_g;
  assign error_red = s_reg.err_r;
  assign maintenance_indicator = s_reg.maintenance_indicator_y;
  assign link_green = s_reg.link_g;
  assign traffic_yellow = s_reg.traf_y;
  assign chan_green = s_reg.chan_g;
  assign chan_red = s_reg.chan_r;
  assign health_green = s_reg.hl_g;
  assign health_red = s_reg.hl_r;
  assign ana_green = s_reg.ana_g;
  assign ana_red = s_reg.ana_r;

  logic plain_c;
  assign plain_c = !all_flash && !hw_defect && !self_test && !fw_update;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_stop_yellow;
    (s_reg.mode == MODE_STOP) && plain_c |=> mode_yellow && !mode_green;
  endproperty
  a_stop_yellow: assert property (p_stop_yellow)
    else $error("stopped mode not shown steady yellow");

  property p_run_green;
    (s_reg.mode == MODE_RUN) && plain_c && !card_remove
      |=> mode_green && !mode_yellow;
  endproperty
  a_run_green: assert property (p_run_green)
    else $error("running mode not shown steady green");

  property p_start_alt;
    alt_mode && !all_flash && !hw_defect
      |=> (mode_green == !$past(ph)) && (mode_yellow == $past(ph))
      && !maintenance_indicator;
  endproperty
  a_start_alt: assert property (p_start_alt)
    else $error("startup lamp pattern wrong");

  sequence s_enter_start;
    (s_reg.mode == MODE_STOP) && run_req && !card_insert && !hw_defect;
  endsequence
  sequence s_quiet;
    (!stop_req && !card_insert && !hw_defect) [*8];
  endsequence
  property p_start_len;
    s_enter_start ##1 (s_reg.mode == MODE_START) ##0 s_quiet ##1
      (!stop_req && !card_insert && !hw_defect) [*8]
      |=> s_reg.mode == MODE_RUN;
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("startup did not last its fixed length");

  property p_err_flash;
    err_any && !hw_defect && !all_flash |=> error_red == $past(ph);
  endproperty
  a_err_flash: assert property (p_err_flash)
    else $error("error lamp not flashing on error");

  property p_defect;
    hw_defect && !all_flash
      |=> error_red && mode_yellow && !mode_green && !maintenance_indicator;
  endproperty
  a_defect: assert property (p_defect)
    else $error("defective hardware pattern wrong");

  property p_card_stop;
    card_insert |=> (s_reg.mode == MODE_STOP) && s_reg.card_hold;
  endproperty
  a_card_stop: assert property (p_card_stop)
    else $error("card insertion did not force stop");

  property p_eval;
    s_reg.card_hold && (run_req || memory_reset_command_req) ##1 !$past(s_reg.boot, 1)
      |-> card_eval;
  endproperty
  a_eval: assert property (p_eval)
    else $error("card evaluation not started on request");

  property p_no_eval;
    !s_reg.card_hold && !s_reg.boot |=> !card_eval;
  endproperty
  a_no_eval: assert property (p_no_eval)
    else $error("card evaluation started without cause");

  property p_chan;
    field_power_ok && mod_configured && !mod_updating
      |=> chan_green == $past(dig_state);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel lamp does not mirror channel state");

  property p_field;
    !field_power_ok
      |=> (health_red == $past(ph)) && !health_green
      && (chan_red == {N_DIG{$past(ph)}}) && (chan_green == '0);
  endproperty
  a_field: assert property (p_field)
    else $error("field power loss pattern wrong");

  property p_healthy;
    mod_ok |=> health_green && !health_red;
  endproperty
  a_healthy: assert property (p_healthy)
    else $error("healthy module not steady green");
endmodule
`default_nettype wire

// >>> tb_sled_top.sv
// self-checking bench for the status lamp driver
// assumes sled_pkg, sled_top and the lamp panel model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_sled_top import sled_pkg::*;;
  logic clock = 1'b0, sys_rst = 1'b1, clr = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, card_eval, mode_yellow, mode_green, error_red;
  logic maintenance_indicator, link_green, traffic_yellow;
  logic health_green, health_red;
  logic cpu_internal_error = 1'b0, card_error = 1'b0;
  logic config_mismatch = 1'b0;
  logic hw_defect = 1'b0, fw_defect = 1'b0, self_test = 1'b0;
  logic fw_update = 1'b0;
  logic card_insert = 1'b0, card_remove = 1'b0;
  logic net_link = 1'b0, net_activity = 1'b0;
  logic field_power_ok = 1'b1, mod_configured = 1'b1;
  logic mod_updating = 1'b0;
  logic mod_defect = 1'b0;
  logic [N_DIG-1:0] dig_state = '0, chan_green, chan_red;
  logic [N_ANA-1:0] ana_active = 4'h1, ana_error = 4'h0, ana_green, ana_red;
  logic [8:0] and_v, or_v;
  logic [31:0] r;
  logic e;
  int num_errors = 0, n_compared = 0, n_eval = 0, base;
  // bits: alt, y, g, err, maintenance_indicator, health g, health r, ana g0, ana r0
  wire [8:0] lamp = {mode_yellow ^ mode_green, mode_yellow, mode_green,
    error_red, maintenance_indicator, health_green, health_red,
    ana_green[0], ana_red[0]};
  sled_top #(.FLASH_HALF(4)) uut (.clock, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cpu_internal_error, .card_error, .config_mismatch, .hw_defect,
    .fw_defect, .self_test, .fw_update, .card_insert, .card_remove,
    .net_link, .net_activity, .dig_state, .field_power_ok, .mod_configured,
    .mod_updating, .mod_defect, .ana_active, .ana_error, .card_eval,
    .mode_yellow, .mode_green, .error_red, .maintenance_indicator,
    .link_green, .traffic_yellow, .chan_green, .chan_red, .health_green,
    .health_red, .ana_green, .ana_red);
  sled_lamps panel (.clock, .clr, .lamp, .and_v, .or_v);
  always #2.5 clock = ~clock;
  always @(posedge clock) if (card_eval === 1'b1) n_eval++;
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      give_verdict();
    end
  endtask
  // window of n cycles, then steady/flash judged on masked lamps
  task automatic lamps(input int n, input logic [8:0] m, ea, eo);
    @(posedge clock); clr <= 1'b1;
    @(posedge clock); clr <= 1'b0;
    // one edge more: the panel's sums are read before that edge updates them
    repeat (n + 1) @(posedge clock);
    check({23'h0, and_v & m}, {23'h0, ea & m});
    check({23'h0, or_v & m}, {23'h0, eo & m});
  endtask
  task automatic t_reset;
    repeat (4) @(posedge clock);
    check(n_eval, 1);
    apb(0, ADDR_CTRL, 0); check(r, 32'h4);
    apb(0, ADDR_CMD, 0); check(r, 32'h0);
    apb(0, 12'h00C, 0); check({r[30:0], e}, 32'h1);
    apb(0, ADDR_STAT, 0); check(r[2:0], 3'b001);
    $display("reset test done");
  endtask
  task automatic t_modes;
    lamps(12, 9'h0F0, 9'h080, 9'h080);
    apb(1, ADDR_CMD, 32'h1);
    lamps(10, 9'h1D0, 9'h100, 9'h1C0);
    repeat (20) @(posedge clock);
    apb(0, ADDR_STAT, 0); check(r[2:0], 3'b100);
    lamps(12, 9'h0F0, 9'h040, 9'h040);
    apb(1, ADDR_CMD, 32'h2);
    apb(0, ADDR_STAT, 0); check(r[2:0], 3'b001);
    @(posedge clock); self_test <= 1;
    lamps(12, 9'h1D0, 9'h100, 9'h1C0);
    self_test <= 0; fw_update <= 1;
    lamps(12, 9'h1D0, 9'h100, 9'h1C0);
    fw_update <= 0;
    $display("mode test done");
  endtask
  task automatic t_errors;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      {cpu_internal_error, card_error, config_mismatch} <= 3'b100 >> i;
      lamps(16, 9'h0F0, 9'h080, 9'h0A0);
    end
    {cpu_internal_error, card_error, config_mismatch} <= 3'b000;
    apb(1, ADDR_CMD, 32'h1);
    repeat (20) @(posedge clock);
    hw_defect <= 1;
    lamps(12, 9'h0F0, 9'h0A0, 9'h0A0);
    apb(0, ADDR_STAT, 0); check(r[2:0], 3'b001);
    hw_defect <= 0;
    $display("error test done");
  endtask
  task automatic t_card;
    apb(1, ADDR_CMD, 32'h1);
    repeat (20) @(posedge clock);
    base = n_eval;
    card_insert <= 1;
    @(posedge clock); card_insert <= 0;
    lamps(16, 9'h0D0, 9'h080, 9'h090);
    apb(0, ADDR_STAT, 0); check(r[3:0], 4'h9);
    check(n_eval - base, 0);
    apb(1, ADDR_CMD, 32'h1);
    repeat (3) @(posedge clock);
    check(n_eval - base, 1);
    card_insert <= 1;
    @(posedge clock); card_insert <= 0;
    apb(1, ADDR_CMD, 32'h4);
    repeat (3) @(posedge clock);
    check(n_eval - base, 2);
    apb(0, ADDR_STAT, 0); check(r[3:0], 4'h1);
    card_remove <= 1;
    lamps(16, 9'h0D0, 9'h080, 9'h090);
    card_remove <= 0;
    $display("card test done");
  endtask
  task automatic t_maintenance_indicator;
    apb(1, ADDR_CTRL, 32'h5);
    lamps(12, 9'h0D0, 9'h090, 9'h090);
    apb(1, ADDR_CMD, 32'h1);
    repeat (20) @(posedge clock);
    lamps(12, 9'h0D0, 9'h050, 9'h050);
    apb(1, ADDR_CMD, 32'h2);
    apb(1, ADDR_CTRL, 32'h6);
    lamps(16, 9'h1F0, 9'h100, 9'h1F0);
    apb(1, ADDR_CTRL, 32'h4);
    fw_defect <= 1;
    lamps(16, 9'h1F0, 9'h100, 9'h1F0);
    fw_defect <= 0;
    $display("maintenance test done");
  endtask
  task automatic t_net;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {net_link, net_activity} <= i[1:0];
      dig_state <= 16'hA5C3 ^ (16'h0F0F << i);
      repeat (3) @(posedge clock);
      check(link_green, i[1]);
      check(traffic_yellow, i[0]);
      check(chan_green, 16'hA5C3 ^ (16'h0F0F << i));
    end
    $display("network test done");
  endtask
  task automatic t_module;
    field_power_ok <= 0;
    lamps(16, 9'h00F, 9'h000, 9'h005);
    check(chan_red, {16{health_red}});
    check(ana_red, {4{health_red}});
    check(chan_green, 16'h0000);
    repeat (4) @(posedge clock);
    check(chan_red, {16{health_red}});
    field_power_ok <= 1'b1; mod_configured <= 1'b0;
    lamps(16, 9'h00F, 9'h000, 9'h008);
    check(chan_green, 16'h0000);
    mod_configured <= 1'b1; mod_updating <= 1'b1;
    lamps(16, 9'h00F, 9'h000, 9'h008);
    check(chan_green, 16'h0000);
    mod_updating <= 1'b0;
    lamps(12, 9'h00F, 9'h00A, 9'h00A);
    check(ana_green, 4'h1);
    check(ana_red, 4'h0);
    check(chan_green, dig_state);
    check(chan_red, 16'h0000);
    mod_defect <= 1;
    lamps(12, 9'h00C, 9'h004, 9'h004);
    mod_defect <= 0; ana_error <= 4'h1;
    lamps(16, 9'h001, 9'h000, 9'h001);
    apb(1, ADDR_CTRL, 32'h0);
    lamps(12, 9'h003, 9'h002, 9'h002);
    $display("module test done");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 0;
    t_reset();
    t_modes();
    t_errors();
    t_card();
    t_maintenance_indicator();
    t_net();
    t_module();
    give_verdict();
  end
endmodule
`default_nettype wire
